// *** test/uilm_core_model.sv ***
// Stand-in for the UART core: fill counts and error pulses.
// Assumes its tasks are called from the bench's clocked flow.
`timescale 1ns/1ps
`default_nettype none
module uilm_core_model
	import uilm_pkg::*;
(
	input wire logic clk_i,
	output logic [4:0] rx_o = '0,
	output logic [4:0] tx_o = '0,
	output uilm_event_s ev_o = '0,
	output logic cts_n_o = 1'b1
);
	task fill(input int r, input int t);
		@(posedge clk_i);
		rx_o <= 5'(r);
		tx_o <= 5'(t);
		repeat (3) @(posedge clk_i);
	endtask : fill
	task pulse(input uilm_event_s e);
		@(posedge clk_i);
		ev_o <= e;
		repeat (2) @(posedge clk_i);
		ev_o <= '0;
	endtask : pulse
	task set_cts(input logic v);
		@(posedge clk_i);
		cts_n_o <= v;
		repeat (4) @(posedge clk_i);
	endtask : set_cts
endmodule : uilm_core_model
`default_nettype wire

// *** test/uilm_irq_properties.sv ***
// Port assertions for uilm_irq.
// Assumes a bind onto uilm_irq.
`timescale 1ns/1ps
`default_nettype none
module uilm_irq_properties
	import uilm_pkg::*;
#(parameter int DEPTH = 16)
(
	input wire logic clk_i, reset_i, psel_i, penable_i, pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire uilm_event_s events_i,
	input wire logic [$clog2(DEPTH):0] rx_level_i,
	input wire logic [10:0] irq_vector_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	wire acc = psel_i && penable_i && pwrite_i;
	wire mwr = acc && paddr_i == 12'h004;
	wire cwr = acc && paddr_i == 12'h010;
	or_out_a: assert property (irq_o == |irq_vector_o)
		else $error("or");
	mask_off_a: assert property (
		mwr && pwdata_i[10:4] == 7'h00 && !pwdata_i[1] |=> !irq_o)
		else $error("mask off");
	ovr_mask_a: assert property (
		mwr && pwdata_i[10] && events_i.err_overrun |=> irq_vector_o[10])
		else $error("overrun");
	rxto_mask_a: assert property (
		mwr && pwdata_i[6] && events_i.rx_timeout |=> irq_vector_o[6])
		else $error("timeout");
	cts_mask_a: assert property (
		mwr && pwdata_i[1] && events_i.cts_change |=> irq_vector_o[1])
		else $error("cts");
	ovr_clear_a: assert property (
		cwr && pwdata_i[10] && !events_i.err_overrun |=> !irq_vector_o[10])
		else $error("clear");
	rx_cross_a: assert property (
		$rose(irq_vector_o[4]) |-> $past(mwr) ||
		$past(rx_level_i) != $past(rx_level_i, 2) ||
		$past(rx_level_i, 2) != $past(rx_level_i, 3))
		else $error("rx edge");
	reset_a: assert property ($fell(reset_i) |-> !irq_o)
		else $error("reset");
endmodule : uilm_irq_properties
bind uilm_irq uilm_irq_properties #(.DEPTH(DEPTH)) chk_u (.clk_i, .reset_i,
	.psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .events_i,
	.rx_level_i, .irq_vector_o, .irq_o);
`default_nettype wire

// *** test/uilm_irq_tb.sv ***
// Self-checking bench for uilm_irq over APB.
// Assumes package, checker and core stand-in compiled first.
`timescale 1ns/1ps
`default_nettype none
module uilm_irq_tb
	import uilm_pkg::*;
;
	logic clk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic [11:0] paddr_i = '0;
	logic [31:0] pwdata_i = '0, prdata_o, rd;
	logic pready_o, pslverr_o, er, irq_o, clear_to_send_n_i;
	logic [4:0] rx_level_i, tx_level_i;
	logic [10:0] irq_vector_o;
	uilm_event_s events_i;
	int n_errors = 0, cmp_count = 0, raw_m, mask_m, trig;
	int pos[6] = '{1, 6, 7, 8, 9, 10};
	int eig[5] = '{1, 2, 4, 6, 7};
	always #20 clk_i = ~clk_i;
	uilm_irq #(.DEPTH(16)) dut_u (.clk_i, .reset_i, .psel_i, .penable_i,
		.pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
		.rx_level_i, .tx_level_i, .events_i, .clear_to_send_n_i,
		.irq_vector_o, .irq_o);
	uilm_core_model core_u (.clk_i, .rx_o(rx_level_i), .tx_o(tx_level_i),
		.ev_o(events_i), .cts_n_o(clear_to_send_n_i));
	task test_done;
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (pready_o !== 1'b1 && n < 16);
		if (n >= 16)
		begin
			n_errors++;
			test_done();
		end
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : bus
	initial
	begin
		void'($urandom(17776));
		repeat (20) @(posedge clk_i);
		reset_i <= 1'b0;
		bus(0, 12'h000, 0);
		chk(rd, 32'h12);
		bus(0, 12'h008, 0);
		chk(rd, 0);
		$display("reset test end");
		for (int i = 0; i < 5; i++)
		begin
			mask_m = (i == 4) ? 0 : $urandom & 32'h7f2;
			bus(1, 12'h004, mask_m);
			bus(0, 12'h004, 0);
			chk(rd, mask_m);
		end
		$display("mask test end");
		for (int i = 0; i < 6; i++)
		begin
			raw_m = 1 << pos[i];
			fork
				core_u.pulse(uilm_event_s'(6'(1 << i)));
				bus(1, 12'h004, raw_m);
			join
			bus(1, 12'h008, 32'hffffffff);
			bus(0, 12'h008, 0);
			chk(rd, raw_m);
			chk(irq_o, 1);
			chk(irq_vector_o, raw_m);
			bus(0, 12'h00c, 0);
			chk(rd, raw_m);
			bus(1, 12'h010, raw_m);
			bus(0, 12'h008, 0);
			chk(rd, 0);
		end
		core_u.set_cts(1'b0);
		bus(0, 12'h008, 0);
		chk(rd, 32'h2);
		bus(1, 12'h010, 32'h2);
		bus(0, 12'h008, 0);
		chk(rd, 0);
		$display("event test end");
		bus(1, 12'h004, 32'h30);
		for (int c = 0; c < 5; c++)
		begin
			trig = eig[c] * 2;
			bus(1, 12'h000, c * 9);
			bus(0, 12'h000, 0);
			chk(rd, c * 9);
			core_u.fill(trig - 1, trig + 1);
			bus(1, 12'h010, 32'h7f2);
			core_u.fill(trig, trig);
			bus(0, 12'h008, 0);
			chk(rd, 32'h30);
			chk(irq_o, 1);
			bus(1, 12'h010, 32'h30);
			bus(0, 12'h008, 0);
			chk(rd, 0);
		end
		bus(0, 12'h020, 0);
		chk(er, 1);
		chk(rd, 0);
		$display("level test end");
		test_done();
	end
endmodule : uilm_irq_tb
`default_nettype wire

// *** verilog/uilm_apb_slave.sv ***
// APB slave front end: decodes one access phase into strobes.
// Assumes APB master signals from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "uilm_defs.svh"

module uilm_apb_slave
	import uilm_pkg::*;
(
	// APB
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	output logic pready_o,
	output logic pslverr_o,
	// Decoded strobes
	output logic wr_o,
	output logic rd_o,
	output logic mapped_o
);

	wire logic access = psel_i && penable_i;

	assign mapped_o = (paddr_i == `UILM_OFF_LEVEL_SEL) ||
		(paddr_i == `UILM_OFF_MASK) || (paddr_i == `UILM_OFF_RAW) ||
		(paddr_i == `UILM_OFF_MASKED) || (paddr_i == `UILM_OFF_CLEAR);
	assign pready_o = 1'b1;
	assign pslverr_o = access && !mapped_o;
	assign wr_o = access && pwrite_i && mapped_o;
	assign rd_o = access && !pwrite_i && mapped_o;

endmodule : uilm_apb_slave
`default_nettype wire

// *** verilog/uilm_defs.svh ***
// Register offsets, field positions and reset values of the UART
// interrupt block. Assumes inclusion by the modules; the package does not include it.
`ifndef UILM_DEFS_SVH
`define UILM_DEFS_SVH

// Register byte offsets
`define UILM_OFF_LEVEL_SEL 12'h000
`define UILM_OFF_MASK 12'h004
`define UILM_OFF_RAW 12'h008
`define UILM_OFF_MASKED 12'h00c
`define UILM_OFF_CLEAR 12'h010

// Level select fields
`define UILM_RX_SEL_HI 5
`define UILM_RX_SEL_LO 3
`define UILM_TX_SEL_HI 2
`define UILM_TX_SEL_LO 0
`define UILM_SEL_HALF 3'h2
`define UILM_SEL_MAX 3'h4

// Source bit positions
`define UILM_BIT_OVERRUN 10
`define UILM_BIT_BREAK 9
`define UILM_BIT_PARITY 8
`define UILM_BIT_FRAMING 7
`define UILM_BIT_RX_TIMEOUT 6
`define UILM_BIT_TX 5
`define UILM_BIT_RX 4
`define UILM_BIT_CTS 1

// Bits that hold state in mask and raw registers and that act in the clear register
`define UILM_SRC_MASK 11'h7f2
`define UILM_MASK_RESET 11'h000

`endif

// *** verilog/uilm_irq.sv ***
// UART interrupt block: level select, mask, raw and masked status,
// clear, combined output. Assumes FIFO levels and error pulses come
// from the UART core on clk_i; the CTS pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "uilm_defs.svh"

////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Level interrupts fire only on crossing
// - Trigger levels steer the combined interrupt
// - Trigger levels reset to half full
// - Receive select codes one eighth to seven eighths
// - Transmit select uses same encoding
// - Unsupported fields ignored, read as zero
// - Mask read returns held masks
// - Mask write one sets, zero clears
// - Error masks at bits ten to seven
// - Other masks at bits six, five, four, one
// - Raw status shows state before masking
// - Raw status is read only
// - Raw bits share mask positions
// - Raw bits clear on reset
// - Clear register clears latched interrupts
module uilm_irq
	import uilm_pkg::*;
#(
	parameter int DEPTH = 16
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// APB
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// UART core
	input wire logic [$clog2(DEPTH):0] rx_level_i,
	input wire logic [$clog2(DEPTH):0] tx_level_i,
	input wire uilm_event_s events_i,
	input wire logic clear_to_send_n_i,
	// Interrupts
	output logic [10:0] irq_vector_o,
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////
	// Bus decode
	logic bus_wr;
	logic bus_rd;
	logic bus_mapped;

	uilm_apb_slave u_apb (
		.psel_i(psel_i),
		.penable_i(penable_i),
		.pwrite_i(pwrite_i),
		.paddr_i(paddr_i),
		.pready_o(pready_o),
		.pslverr_o(pslverr_o),
		.wr_o(bus_wr),
		.rd_o(bus_rd),
		.mapped_o(bus_mapped)
	);

	wire logic wr_sel = bus_wr && (paddr_i == `UILM_OFF_LEVEL_SEL);
	wire logic wr_mask = bus_wr && (paddr_i == `UILM_OFF_MASK);
	wire logic wr_clear = bus_wr && (paddr_i == `UILM_OFF_CLEAR);

	////////////////////////////////////////////////////////////////////
	// Level select register
	logic [2:0] rx_trigger_level_sel_q;
	logic [2:0] tx_trigger_level_sel_q;
	wire logic [2:0] rx_sel_wr =
		pwdata_i[`UILM_RX_SEL_HI:`UILM_RX_SEL_LO];
	wire logic [2:0] tx_sel_wr =
		pwdata_i[`UILM_TX_SEL_HI:`UILM_TX_SEL_LO];

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rx_trigger_level_sel_q <= `UILM_SEL_HALF;
			tx_trigger_level_sel_q <= `UILM_SEL_HALF;
		end
		else if (wr_sel)
		begin
			rx_trigger_level_sel_q <= rx_sel_wr;
			tx_trigger_level_sel_q <= tx_sel_wr;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Mask register
	uilm_src_t mask_q;

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			mask_q <= `UILM_MASK_RESET;
		else if (wr_mask)
			mask_q <= pwdata_i[10:0] & `UILM_SRC_MASK;
	end

	////////////////////////////////////////////////////////////////////
	// Level crossing detectors
	logic rx_cross;
	logic tx_cross;

	uilm_level_cross #(.DEPTH(DEPTH), .RISING(1'b1)) u_rx_cross (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.level_i(rx_level_i),
		.sel_i(rx_trigger_level_sel_q),
		.cross_o(rx_cross)
	);

	uilm_level_cross #(.DEPTH(DEPTH), .RISING(1'b0)) u_tx_cross (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.level_i(tx_level_i),
		.sel_i(tx_trigger_level_sel_q),
		.cross_o(tx_cross)
	);

	////////////////////////////////////////////////////////////////////
	// CTS synchroniser and change detect
	logic cts_meta_q;
	logic cts_sync_q;
	logic cts_prev_q;

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			cts_meta_q <= 1'b1;
			cts_sync_q <= 1'b1;
			cts_prev_q <= 1'b1;
		end
		else
		begin
			cts_meta_q <= clear_to_send_n_i;
			cts_sync_q <= cts_meta_q;
			cts_prev_q <= cts_sync_q;
		end
	end

	wire logic cts_change = (cts_sync_q != cts_prev_q) || events_i.cts_change;

	////////////////////////////////////////////////////////////////////
	// Raw status
	uilm_src_t raw_q;
	uilm_src_t set_vec;
	uilm_src_t clr_vec;

	always_comb
	begin
		set_vec = '0;
		set_vec[`UILM_BIT_OVERRUN] = events_i.err_overrun;
		set_vec[`UILM_BIT_BREAK] = events_i.err_break;
		set_vec[`UILM_BIT_PARITY] = events_i.err_parity;
		set_vec[`UILM_BIT_FRAMING] = events_i.err_framing;
		set_vec[`UILM_BIT_RX_TIMEOUT] = events_i.rx_timeout;
		set_vec[`UILM_BIT_TX] = tx_cross;
		set_vec[`UILM_BIT_RX] = rx_cross;
		set_vec[`UILM_BIT_CTS] = cts_change;
	end

	assign clr_vec = wr_clear ? (pwdata_i[10:0] & `UILM_SRC_MASK) : '0;

	// Set wins over a clear in the same cycle
	wire uilm_src_t raw_d = (raw_q & ~clr_vec) | set_vec;

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			raw_q <= '0;
		else
			raw_q <= raw_d;
	end

	////////////////////////////////////////////////////////////////////
	// Masked status and combined output
	wire uilm_src_t masked = raw_q & mask_q;

	assign irq_vector_o = masked;
	assign irq_o = |masked;

	////////////////////////////////////////////////////////////////////
	// Read data
	logic [31:0] rdata_d;

	always_comb
	begin
		rdata_d = '0;
		case (paddr_i)
			`UILM_OFF_LEVEL_SEL:
				rdata_d = {26'h0, rx_trigger_level_sel_q,
					tx_trigger_level_sel_q};
			`UILM_OFF_MASK: rdata_d = {21'h0, mask_q};
			`UILM_OFF_RAW: rdata_d = {21'h0, raw_q};
			`UILM_OFF_MASKED: rdata_d = {21'h0, masked};
			default: rdata_d = '0;
		endcase
	end

	assign prdata_o = (bus_rd && bus_mapped) ? rdata_d : '0;

endmodule : uilm_irq
`default_nettype wire

// *** verilog/uilm_level_cross.sv ***
// Detects a FIFO fill level moving through a selected trigger point.
// Assumes the fill level comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "uilm_defs.svh"

module uilm_level_cross
	import uilm_pkg::*;
#(
	parameter int DEPTH = 16,
	parameter bit RISING = 1'b1
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Level and selection
	input wire logic [$clog2(DEPTH):0] level_i,
	input wire logic [2:0] sel_i,
	// Crossing event
	output logic cross_o
);

	localparam int LW = $clog2(DEPTH) + 1;

	// Elaboration check: trigger arithmetic needs whole eighths
	if (DEPTH < 8 || DEPTH % 8 != 0)
	begin : g_bad_depth
		$error("DEPTH must be a multiple of eight");
	end

	function automatic logic [LW-1:0] trig_of(input logic [2:0] sel);
		logic [LW+2:0] eighths;
		eighths = '0;
		case (sel)
			3'h0: eighths = (LW+3)'(1);
			3'h1: eighths = (LW+3)'(2);
			3'h2: eighths = (LW+3)'(4);
			3'h3: eighths = (LW+3)'(6);
			3'h4: eighths = (LW+3)'(7);
			default: eighths = (LW+3)'(4);
		endcase
		trig_of = LW'((eighths * (LW+3)'(DEPTH)) >> 3);
	endfunction : trig_of

	logic [LW-1:0] prev_q;
	wire logic [LW-1:0] trig = trig_of(sel_i);
	wire logic up_cross = (prev_q < trig) && (level_i >= trig);
	wire logic down_cross = (prev_q > trig) && (level_i <= trig);

	// Only a move through the trigger fires, never a steady level
	assign cross_o = RISING ? up_cross : down_cross;

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			prev_q <= '0;
		else
			prev_q <= level_i;
	end

endmodule : uilm_level_cross
`default_nettype wire

// *** verilog/uilm_pkg.sv ***
// Types of the UART interrupt block.
// Assumes the defs header is on the include path.
package uilm_pkg;

	typedef logic [10:0] uilm_src_t;

	typedef struct packed {
		logic err_overrun;
		logic err_break;
		logic err_parity;
		logic err_framing;
		logic rx_timeout;
		logic cts_change;
	} uilm_event_s;

	typedef enum logic [1:0] {
		UILM_IDLE,
		UILM_ACCESS
	} uilm_apb_e;

endpackage : uilm_pkg
